/* File: dv/display_output_stage_test.sv */
// self-checking bench of the display output stage
`timescale 1ns/1ps
module display_output_stage_test;
	import dos_pkg::*;
	logic        clk, rst, wr_en, rd_en, pixel_clock_in, clock_gate, pixel_is_yuv, hblank, vblank, ck_int;
	logic        link_on, panel_sync_en, ext_h, ext_v, ext_r, pclk_pin, ck_o, ck_oe, dac_oe, yuv422;
	logic [15:0] addr;
	logic [31:0] wdata, rd_data, word, rnd, ena, seed, gam;
	logic [23:0] pixel_in, pins_o, pins_oe, data_seen, expd, dcl, acl;
	logic [2:0]  sync_int, sync_o, sync_oe, sync_wire, panel_sync;
	logic [7:0]  dac_r, dac_g, dac_b;
	int          n_mismatch, compares, i, y, g, hi, e;

	// clocks: 50 ns system, 400 ns link clock only while link_on
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		pixel_clock_in = 1'b0;
		#13;
		forever #200 pixel_clock_in = link_on ? ~pixel_clock_in : 1'b0;
	end

	dos_display_output_stage dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .pixel_clock_in(pixel_clock_in), .clock_gate(clock_gate),
		.pixel_in(pixel_in), .pixel_is_yuv(pixel_is_yuv), .pixel_yuv422(yuv422), .hblank(hblank),
		.vblank(vblank), .hsync_int(sync_int[0]), .vsync_int(sync_int[1]), .vref_int(sync_int[2]),
		.colour_key_int(ck_int), .ext_hsync(ext_h), .ext_vsync(ext_v), .ext_vref(ext_r),
		.pixel_clock_pin_o(pclk_pin), .pixel_data_pins_o(pins_o), .pixel_data_pins_oe(pins_oe),
		.hsync_pin_i(sync_wire[0]), .hsync_pin_o(sync_o[0]), .hsync_pin_oe(sync_oe[0]),
		.vsync_pin_i(sync_wire[1]), .vsync_pin_o(sync_o[1]), .vsync_pin_oe(sync_oe[1]),
		.vertical_reference_pin_i(sync_wire[2]), .vertical_reference_pin_o(sync_o[2]),
		.vertical_reference_pin_oe(sync_oe[2]), .colour_key_pin_o(ck_o), .colour_key_pin_oe(ck_oe),
		.dac_red(dac_r), .dac_green(dac_g), .dac_blue(dac_b), .dac_oe(dac_oe));
	dos_panel_model panel_u (.clk(clk), .panel_sync_en(panel_sync_en), .panel_sync(panel_sync),
		.sync_o(sync_o), .sync_oe(sync_oe), .data_o(pins_o), .data_oe(pins_oe), .sync_wire(sync_wire),
		.data_seen(data_seen));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// bus cycles: one strobe cycle, then one idle edge
	task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
		@(posedge clk);
	endtask
	// two link clock periods, then the pin update latency
	task automatic px_wait();
		repeat (2) @(posedge pixel_clock_in);
		repeat (6) @(posedge clk);
	endtask
	task automatic complete_run();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#2_000_000;
		n_mismatch++;
		complete_run();
	end

	initial begin
		seed = 32'h0000_daaa;
		{rst, wr_en, rd_en, clock_gate, pixel_is_yuv, hblank, vblank, ck_int, link_on, panel_sync_en} = 10'h200;
		{addr, wdata, pixel_in, sync_int, panel_sync, yuv422} = '0;
		n_mismatch = 0;
		compares = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		reg_rd(ENABLES_OFS, word);
		check(word, 32'h0000_0000);
		reg_rd(COEF_G_OFS, word);
		check(word, 32'h0080_0000);
		reg_rd(16'h3ffc, word);
		check(word, 32'h0000_0000);
		// enables and sync direction, internal then external sync
		for (i = 0; i < 4; i++) begin
			ena = xs();
			rnd = xs();
			reg_wr(CTRL_OFS, {31'h0, i[0]});
			reg_wr(ENABLES_OFS, ena);
			sync_int <= rnd[2:0];
			ck_int <= rnd[3];
			panel_sync <= rnd[6:4];
			panel_sync_en <= i[0];
			// let the panel levels pass the synchronisers
			repeat (2) @(posedge clk);
			reg_rd(ENABLES_OFS, word);
			check(word, {2'h0, ena[29:0]});
			check({8'h0, pins_oe}, {8'h0, ena[23:0]});
			check({27'h0, ck_o, ck_oe, sync_oe}, {27'h0, rnd[3], ena[27], ena[26:24] & {3{~i[0]}}});
			if (i[0]) check({29'h0, ext_r, ext_v, ext_h}, {29'h0, rnd[6:4]});
			else check({29'h0, sync_o}, {29'h0, rnd[2:0]});
		end
		// pixels and clamps; disabled data pins must float at the panel
		reg_wr(FORMAT_OFS, {13'h0, 1'b0, single_scan_mode, 4'h0, analog_stream_format, 4'h0, PHYS_RGB888});
		dcl = 24'(xs());
		acl = 24'(xs());
		reg_wr(DCLAMP_OFS, {8'h0, dcl});
		reg_wr(ACLAMP_OFS, {8'h0, acl});
		link_on <= 1'b1;
		for (i = 0; i < 4; i++) begin
			rnd = xs();
			hblank <= i[0];
			vblank <= i[1];
			pixel_in <= rnd[23:0];
			px_wait();
			for (e = 0; e < 24; e++) expd[e] = ena[e] ? ((i != 0) ? dcl[e] : rnd[e]) : 1'bz;
			check({8'h0, data_seen}, {8'h0, expd});
			check({8'h0, dac_r, dac_g, dac_b}, {8'h0, (i != 0) ? acl : rnd[23:0]});
		end
		// analog output enable over random format and enable settings
		for (i = 0; i < 64; i++) begin
			rnd = xs();
			reg_wr(FORMAT_OFS, {13'h0, rnd[18], rnd[17] & rnd[19], rnd[16] & rnd[19], 4'h0,
				4'h5 + {1'b0, rnd[10:8]}, 4'h0, 1'b0, rnd[2:0] | {rnd[3], 2'h0}});
			reg_wr(ENABLES_OFS, {2'h0, rnd[29:28] | {2{rnd[30]}}, 28'h0});
			e = (rnd[17:16] & {2{rnd[19]}}) == 2'h0 && (rnd[29:28] | {2{rnd[30]}}) == 2'h3;
			y = rnd[2:0] | {rnd[3], 2'h0};
			g = 5 + rnd[10:8];
			hi = (!rnd[18] && y == 6 && g == 9) || (rnd[18] && y >= 3 && y <= 6 && g >= 5 && g <= 8);
			check({31'h0, dac_oe}, {31'h0, e != 0 && hi != 0});
		end
		// matrix with luma bias and subtracted blue difference coefficient
		reg_wr(FORMAT_OFS, {13'h0, 1'b0, single_scan_mode, 4'h0, analog_stream_format, 4'h0, PHYS_RGB888});
		reg_wr(CTRL_OFS, 32'h0000_0004);
		reg_wr(BIAS_OFS, 32'h00f0_0000);
		reg_wr(COEF_G_OFS, 32'h0080_4000);
		{hblank, vblank, pixel_is_yuv} <= 3'h1;
		pixel_in <= 24'h80_2000;
		px_wait();
		y = 128 - 16;
		g = (y * 128 - 32 * 64) / 128;
		check({8'h0, dac_r, dac_g, dac_b}, {8'h0, y[7:0], g[7:0], y[7:0]});
		// gamma table lookup only while enabled
		gam = xs();
		reg_wr(GAMMA_TAB_OFS + 16'h00c0, {8'h0, gam[23:0]});
		reg_wr(GAMMA_CTRL_OFS, 32'h0000_0080);
		pixel_in <= 24'h40_0000;
		px_wait();
		check({8'h0, dac_r, dac_g, dac_b}, {8'h0, gam[23:0]});
		reg_wr(GAMMA_CTRL_OFS, 32'h0000_0000);
		px_wait();
		check({8'h0, dac_r, dac_g, dac_b}, 32'h0030_3030);
		// chroma averaged with the previous pixel
		reg_wr(CTRL_OFS, 32'h0000_0006);
		@(posedge pixel_clock_in);
		repeat (4) @(posedge clk);
		pixel_in <= 24'h80_4000;
		yuv422 <= 1'b1;
		@(posedge pixel_clock_in);
		repeat (6) @(posedge clk);
		g = (y * 128 - ((64 + 0) / 2) * 64) / 128;
		check({8'h0, dac_r, dac_g, dac_b}, {8'h0, y[7:0], g[7:0], y[7:0]});
		// 4bpp to 1bpp, level 5 with a full duty entry on, level 1 with an empty duty entry off
		reg_wr(CTRL_OFS, 32'h0000_0020);
		reg_wr(FORMAT_OFS, {28'h0, PHYS_1BPP});
		reg_wr(LEVELS_OFS + 16'h0010, 32'h0000_00ff);
		for (i = 0; i < 2; i++) begin
			pixel_in <= i[0] ? 24'h00_0001 : 24'h00_0005;
			px_wait();
			check({8'h0, pins_o}, {31'h0, !i[0]});
		end
		// gated pixel clock: closed gate gives no pulses, open gate about half high
		for (i = 0; i < 2; i++) begin
			clock_gate <= i[0];
			repeat (16) @(posedge clk);
			hi = 0;
			repeat (80) begin
				@(posedge clk);
				hi += pclk_pin;
			end
			check({31'h0, i[0] ? (hi >= 32 && hi <= 48) : (hi == 0)}, 32'h0000_0001);
		end
		complete_run();
	end
endmodule

/* File: dv/dos_panel_model.sv */
// display panel model: sync pin levels and what the panel sees on the data pins
`timescale 1ns/1ps
module dos_panel_model (
	input  wire logic        clk,
	input  wire logic        panel_sync_en,
	input  wire logic [2:0]  panel_sync,
	input  wire logic [2:0]  sync_o,
	input  wire logic [2:0]  sync_oe,
	input  wire logic [23:0] data_o,
	input  wire logic [23:0] data_oe,
	output logic      [2:0]  sync_wire,
	output logic      [23:0] data_seen
);
	logic [2:0] last_reg = 3'h0;
	// panel drives sync pins only in external sync
	// undriven lines show a changing pattern, never the held value
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			sync_wire[i] = sync_oe[i] ? sync_o[i] : (panel_sync_en ? panel_sync[i] : ~last_reg[i]);
		end
	end
	always_ff @(posedge clk) begin
		last_reg <= sync_wire;
	end
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			data_seen[i] = data_oe[i] ? data_o[i] : 1'bz;
		end
	end
endmodule

/* File: rtl/dos_display_output_stage.sv */
// display output stage: pin drivers, clamps, colour matrix, gamma and duty ratio modulation
// Behaviour
// - pixel clock pin gated by the gate control from the seventh sync mixer.
// - external sync makes sync pins inputs; internal sync drives them.
// - each data pin is high impedance when its output enable bit is clear.
// - colour key pin has its enable; sync pin enables apply only under internal sync.
// - analog outputs drive only in single scan with DAC and reference enabled.
// - analog primary: twin off, RGB888, analog stream format.
// - analog secondary: twin on, RGB333..RGB888, stream S9..S24.
// - analog clamp value drives analog outputs during blanking.
// - digital clamp value drives data pins during blanking.
// - three signed 8-bit biases added to luma and chroma before the matrix.
// - blue and red difference to green coefficients are subtracted.
// - matrix results go through the gamma table only when gamma is enabled.
// - optional chroma interpolation for YUV422 data.
// - pixel width limited by the physical colour space in RGB333, RGB444 and RGB666.
// - duty ratio modulation for 4bpp to 1bpp and RGB222 to RGB111.
// - enable bits 24..26 for sync outputs, bit 27 for colour key.
// - analog clamp holds red, green, blue in bytes two, one, zero.
`timescale 1ns/1ps
module dos_display_output_stage
	import dos_pkg::*;
(
	input  logic        clk,
	input  logic        rst,
	input  logic [15:0] addr,
	input  logic [31:0] wdata,
	input  logic        wr_en,
	input  logic        rd_en,
	output logic [31:0] rd_data,
	input  logic        pixel_clock_in,
	input  logic        clock_gate,
	input  logic [23:0] pixel_in,
	input  logic        pixel_is_yuv,
	input  logic        pixel_yuv422,
	input  logic        hblank,
	input  logic        vblank,
	input  logic        hsync_int,
	input  logic        vsync_int,
	input  logic        vref_int,
	input  logic        colour_key_int,
	output logic        ext_hsync,
	output logic        ext_vsync,
	output logic        ext_vref,
	output logic        pixel_clock_pin_o,
	output logic [23:0] pixel_data_pins_o,
	output logic [23:0] pixel_data_pins_oe,
	input  logic        hsync_pin_i,
	output logic        hsync_pin_o,
	output logic        hsync_pin_oe,
	input  logic        vsync_pin_i,
	output logic        vsync_pin_o,
	output logic        vsync_pin_oe,
	input  logic        vertical_reference_pin_i,
	output logic        vertical_reference_pin_o,
	output logic        vertical_reference_pin_oe,
	output logic        colour_key_pin_o,
	output logic        colour_key_pin_oe,
	output logic [7:0]  dac_red,
	output logic [7:0]  dac_green,
	output logic [7:0]  dac_blue,
	output logic        dac_oe
);

	typedef struct packed {
		logic [7:0]                  ctrl;
		logic [18:0]                 format;
		logic [29:0]                 enables;
		logic [23:0]                 aclamp;
		logic [23:0]                 dclamp;
		logic                        gamma_en;
		logic [23:0]                 bias;
		logic [23:0]                 coef_g;
		logic [15:0]                 coef_r;
		logic [15:0]                 coef_b;
		logic [LEVELS_N-1:0][7:0]    levels;
		logic [GAMMA_N-1:0][23:0]    gamma;
		logic [31:0]                 rd_data;
		logic                        pclk_s1;
		logic                        pclk_s2;
		logic                        pclk_s3;
		logic                        hs_s1;
		logic                        hs_s2;
		logic                        vs_s1;
		logic                        vs_s2;
		logic                        vr_s1;
		logic                        vr_s2;
		logic                        gate_q;
		logic                        pclk_out;
		logic [23:0]                 data_out;
		logic [23:0]                 dac_out;
		logic [7:0]                  u_prev;
		logic                        vblank_d;
		logic [7:0]                  frame_cnt;
		logic                        hs_o;
		logic                        vs_o;
		logic                        vr_o;
		logic                        ck_o;
	} dos_state_type;

	dos_state_type st_reg;
	dos_state_type st_next;

	// averages two chroma samples
	function automatic logic [7:0] avg8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[8:1];
	endfunction

	// value times 1.7 fixed point coefficient magnitude
	function automatic logic signed [17:0] mul(input logic [7:0] v, input logic sgn, input logic [7:0] c);
		return $signed({sgn & v[7], v}) * $signed({1'b0, c});
	endfunction

	// scales back by 128 and saturates to one byte
	function automatic logic [7:0] clip(input logic signed [19:0] s);
		logic signed [19:0] q;
		q = s >>> 7;
		if (q < 20'sd0) begin
			return 8'h00;
		end else if (q > 20'sd255) begin
			return 8'hff;
		end
		return q[7:0];
	endfunction

	// keeps only the bits each channel has in RGB333, RGB444 and RGB666; other spaces keep all eight
	function automatic logic [23:0] mask_rgb(input logic [23:0] rgb, input logic [3:0] phys);
		logic [7:0] m;
		case (phys)
			PHYS_RGB333: m = 8'he0;
			PHYS_RGB444: m = 8'hf0;
			PHYS_RGB666: m = 8'hfc;
			default:     m = 8'hff;
		endcase
		return rgb & {m, m, m};
	endfunction

	// one duty-ratio modulated bit for a pseudo level
	function automatic logic duty(input logic [3:0] lvl, input logic [LEVELS_N-1:0][7:0] lv,
			input logic [7:0] cnt);
		if (lvl == 4'h0) begin
			return 1'b0;
		end else if (lvl == 4'hf) begin
			return 1'b1;
		end
		return cnt < lv[4'(lvl - 4'h1)];
	endfunction

	// decoded configuration fields
	logic [3:0] phys;
	logic [3:0] stream;
	logic [1:0] scan;
	logic       twin;
	logic       ext_sync;
	logic [3:0] inter;
	logic       dac_primary;
	logic       dac_secondary;
	logic       pix_rise;
	logic       blank;
	assign phys     = st_reg.format[FMT_PHYS_LSB+:4];
	assign stream   = st_reg.format[FMT_STREAM_LSB+:4];
	assign scan     = st_reg.format[FMT_SCAN_LSB+:2];
	assign twin     = st_reg.format[FMT_TWIN_BIT];
	assign ext_sync = st_reg.ctrl[CTRL_EXT_SYNC];
	assign inter    = st_reg.ctrl[CTRL_INTER_LSB+:4];
	assign pix_rise = st_reg.pclk_s2 && !st_reg.pclk_s3;
	assign blank    = hblank || vblank;

	assign dac_primary = !twin && (phys == PHYS_RGB888) && (stream == analog_stream_format);
	assign dac_secondary = twin && (phys >= PHYS_RGB333) && (phys <= PHYS_RGB888)
		&& (stream >= STREAM_S9) && (stream <= STREAM_S24);
	assign dac_oe = (scan == single_scan_mode) && st_reg.enables[ENA_DAC_BIT]
		&& st_reg.enables[ENA_REF_BIT] && (dac_primary || dac_secondary);

	// chroma interpolation and biasing
	logic [7:0] y_b;
	logic [7:0] u_in;
	logic [7:0] u_b;
	logic [7:0] v_b;
	// average chroma with the previous pixel for 4:2:2 data
	assign u_in = (st_reg.ctrl[CTRL_CHROMA_INT] && pixel_yuv422) ? avg8(pixel_in[15:8], st_reg.u_prev)
		: pixel_in[15:8];
	// signed pre-matrix biases, wrapping in eight bits
	assign y_b = pixel_in[23:16] + st_reg.bias[23:16];
	assign u_b = u_in + st_reg.bias[15:8];
	assign v_b = pixel_in[7:0] + st_reg.bias[7:0];

	// matrix products
	logic signed [19:0] r_sum;
	logic signed [19:0] g_sum;
	logic signed [19:0] b_sum;
	assign r_sum = 20'(mul(y_b, 1'b0, st_reg.coef_r[15:8])) + 20'(mul(v_b, 1'b1, st_reg.coef_r[7:0]));
	// difference to green terms are negative
	assign g_sum = 20'(mul(y_b, 1'b0, st_reg.coef_g[23:16])) - 20'(mul(u_b, 1'b1, st_reg.coef_g[15:8]))
		- 20'(mul(v_b, 1'b1, st_reg.coef_g[7:0]));
	assign b_sum = 20'(mul(y_b, 1'b0, st_reg.coef_b[15:8])) + 20'(mul(u_b, 1'b1, st_reg.coef_b[7:0]));

	// colour path after matrix and gamma
	logic [23:0] base_rgb;
	logic [23:0] gam_rgb;
	logic [23:0] pix_rgb;
	logic [23:0] pin_pixel;
	assign base_rgb = (st_reg.ctrl[CTRL_MATRIX_EN] && pixel_is_yuv)
		? {clip(r_sum), clip(g_sum), clip(b_sum)} : pixel_in;
	// gamma lookup only with the enable set
	assign gam_rgb = st_reg.gamma_en ? {st_reg.gamma[base_rgb[23:16]][23:16],
		st_reg.gamma[base_rgb[15:8]][15:8], st_reg.gamma[base_rgb[7:0]][7:0]} : base_rgb;
	// effective width follows the physical space in RGB333, RGB444 and RGB666
	assign pix_rgb = mask_rgb(gam_rgb, phys);

	always_comb begin
		if (inter == INTER_4BPP && phys == PHYS_1BPP) begin
			pin_pixel = {23'h00_0000, duty(pixel_in[3:0], st_reg.levels, st_reg.frame_cnt)};
		end else if (inter == INTER_RGB222 && phys == PHYS_RGB111) begin
			pin_pixel = {21'h00_0000,
				duty({2{pixel_in[23:22]}}, st_reg.levels, st_reg.frame_cnt),
				duty({2{pixel_in[15:14]}}, st_reg.levels, st_reg.frame_cnt),
				duty({2{pixel_in[7:6]}}, st_reg.levels, st_reg.frame_cnt)};
		end else begin
			pin_pixel = pix_rgb;
		end
	end

	// register index helpers
	logic [15:0] lev_ofs;
	logic [3:0]  lev_idx;
	logic [7:0]  gam_idx;
	logic        is_lev;
	logic        is_gam;
	assign lev_ofs = addr - LEVELS_OFS;
	assign lev_idx = lev_ofs[5:2];
	assign gam_idx = addr[9:2];
	assign is_lev  = (addr >= LEVELS_OFS) && (addr <= LEVELS_LAST_OFS) && (addr[1:0] == 2'h0);
	assign is_gam  = (addr >= GAMMA_TAB_OFS) && (addr <= GAMMA_TAB_LAST_OFS) && (addr[1:0] == 2'h0);

	// next state: synchronisers, register file and pixel output
	always_comb begin
		st_next = st_reg;
		// link clock and sync inputs pass two flops
		st_next.pclk_s1 = pixel_clock_in;
		st_next.pclk_s2 = st_reg.pclk_s1;
		st_next.pclk_s3 = st_reg.pclk_s2;
		st_next.hs_s1   = hsync_pin_i;
		st_next.hs_s2   = st_reg.hs_s1;
		st_next.vs_s1   = vsync_pin_i;
		st_next.vs_s2   = st_reg.vs_s1;
		st_next.vr_s1   = vertical_reference_pin_i;
		st_next.vr_s2   = st_reg.vr_s1;
		// gate changes only while the clock is low
		if (!st_reg.pclk_s2) begin
			st_next.gate_q = clock_gate;
		end
		st_next.pclk_out = st_reg.pclk_s2 && st_reg.gate_q;
		// frame counter for duty ratio phases
		st_next.vblank_d = vblank;
		if (vblank && !st_reg.vblank_d) begin
			st_next.frame_cnt = st_reg.frame_cnt + 8'h01;
		end
		// sync and key outputs follow the timing logic
		st_next.hs_o = hsync_int;
		st_next.vs_o = vsync_int;
		st_next.vr_o = vref_int;
		st_next.ck_o = colour_key_int;
		// register writes
		if (wr_en) begin
			if (addr == CTRL_OFS) begin
				st_next.ctrl = wdata[7:0];
			end else if (addr == FORMAT_OFS) begin
				st_next.format = wdata[18:0];
			end else if (addr == ENABLES_OFS) begin
				st_next.enables = wdata[29:0];
			end else if (addr == ACLAMP_OFS) begin
				st_next.aclamp = wdata[23:0];
			end else if (addr == DCLAMP_OFS) begin
				st_next.dclamp = wdata[23:0];
			end else if (addr == GAMMA_CTRL_OFS) begin
				st_next.gamma_en = wdata[GAMMA_EN_BIT];
			end else if (addr == BIAS_OFS) begin
				st_next.bias = wdata[23:0];
			end else if (addr == COEF_G_OFS) begin
				st_next.coef_g = wdata[23:0];
			end else if (addr == COEF_R_OFS) begin
				st_next.coef_r = wdata[15:0];
			end else if (addr == COEF_B_OFS) begin
				st_next.coef_b = wdata[15:0];
			end else if (is_lev) begin
				st_next.levels[lev_idx] = wdata[7:0];
			end else if (is_gam) begin
				st_next.gamma[gam_idx] = wdata[23:0];
			end
		end
		// register reads, data valid the next cycle only
		st_next.rd_data = 32'h0000_0000;
		if (rd_en) begin
			if (addr == CTRL_OFS) begin
				st_next.rd_data = {24'h00_0000, st_reg.ctrl};
			end else if (addr == FORMAT_OFS) begin
				st_next.rd_data = {13'h0000, st_reg.format};
			end else if (addr == STATUS_OFS) begin
				st_next.rd_data = {16'h0000, st_reg.frame_cnt, 3'h0, dac_secondary, dac_primary,
					dac_oe, vblank, hblank};
			end else if (addr == ENABLES_OFS) begin
				st_next.rd_data = {2'h0, st_reg.enables};
			end else if (addr == ACLAMP_OFS) begin
				st_next.rd_data = {8'h00, st_reg.aclamp};
			end else if (addr == DCLAMP_OFS) begin
				st_next.rd_data = {8'h00, st_reg.dclamp};
			end else if (addr == GAMMA_CTRL_OFS) begin
				st_next.rd_data = {24'h00_0000, st_reg.gamma_en, 7'h00};
			end else if (addr == BIAS_OFS) begin
				st_next.rd_data = {8'h00, st_reg.bias};
			end else if (addr == COEF_G_OFS) begin
				st_next.rd_data = {8'h00, st_reg.coef_g};
			end else if (addr == COEF_R_OFS) begin
				st_next.rd_data = {16'h0000, st_reg.coef_r};
			end else if (addr == COEF_B_OFS) begin
				st_next.rd_data = {16'h0000, st_reg.coef_b};
			end else if (is_lev) begin
				st_next.rd_data = {24'h00_0000, st_reg.levels[lev_idx]};
			end else if (is_gam) begin
				st_next.rd_data = {8'h00, st_reg.gamma[gam_idx]};
			end
		end
		// new output pixel on each link clock rising edge
		if (pix_rise) begin
			st_next.u_prev = pixel_in[15:8];
			// clamp in any blanked pixel clock
			if (blank) begin
				st_next.data_out = st_reg.dclamp;
				st_next.dac_out = st_reg.aclamp;
			end else begin
				st_next.data_out = pin_pixel;
				st_next.dac_out = pix_rgb;
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg        <= '0;
			st_reg.bias   <= BIAS_RST;
			st_reg.coef_g <= COEF_G_RST;
			st_reg.coef_r <= COEF_R_RST;
			st_reg.coef_b <= COEF_B_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs
	assign rd_data            = st_reg.rd_data;
	assign pixel_clock_pin_o  = st_reg.pclk_out;
	assign pixel_data_pins_o  = st_reg.data_out;
	assign pixel_data_pins_oe = st_reg.enables[23:0];
	// sync pins driven only under internal sync
	assign hsync_pin_o               = st_reg.hs_o;
	assign vsync_pin_o               = st_reg.vs_o;
	assign vertical_reference_pin_o  = st_reg.vr_o;
	// sync enables only count under internal sync
	assign hsync_pin_oe              = !ext_sync && st_reg.enables[ENA_HSYNC_BIT];
	assign vsync_pin_oe              = !ext_sync && st_reg.enables[ENA_VSYNC_BIT];
	assign vertical_reference_pin_oe = !ext_sync && st_reg.enables[ENA_VREF_BIT];
	assign colour_key_pin_o          = st_reg.ck_o;
	assign colour_key_pin_oe         = st_reg.enables[ENA_CKEY_BIT];
	assign ext_hsync = st_reg.hs_s2;
	assign ext_vsync = st_reg.vs_s2;
	assign ext_vref  = st_reg.vr_s2;
	assign dac_red   = st_reg.dac_out[23:16];
	assign dac_green = st_reg.dac_out[15:8];
	assign dac_blue  = st_reg.dac_out[7:0];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_pix_edge;
		st_reg.pclk_s2 && !st_reg.pclk_s3;
	endsequence
	sequence s_blank_edge;
		s_pix_edge ##0 blank;
	endsequence

	a_data_oe_write: assert property ((wr_en && addr == ENABLES_OFS) |=> pixel_data_pins_oe == $past(wdata[23:0]))
		else $error("data pin enables do not follow write");
	a_ckey_oe_write: assert property ((wr_en && addr == ENABLES_OFS) |=> colour_key_pin_oe == $past(wdata[27]))
		else $error("colour key enable does not follow write");
	a_sync_direction: assert property (ext_sync |-> !hsync_pin_oe && !vsync_pin_oe && !vertical_reference_pin_oe)
		else $error("sync pin driven under external sync");
	a_dac_gate: assert property (dac_oe |-> scan == single_scan_mode && st_reg.enables[28] && st_reg.enables[29])
		else $error("dac driven without enables");
	a_dac_primary: assert property ((scan == single_scan_mode && st_reg.enables[29:28] == 2'h3 && !twin
		&& phys == PHYS_RGB888 && stream == analog_stream_format) |-> dac_oe)
		else $error("primary analog display not driven");
	a_digital_clamp: assert property (s_blank_edge |=> pixel_data_pins_o == $past(st_reg.dclamp))
		else $error("digital clamp missing in blanking");
	a_analog_clamp: assert property (s_blank_edge |=> {dac_red, dac_green, dac_blue} == $past(st_reg.aclamp))
		else $error("analog clamp missing in blanking");
	a_pixel_hold: assert property (!pix_rise |=> $stable(pixel_data_pins_o))
		else $error("pixel pins changed without pixel clock");
	a_clock_gated: assert property (!st_reg.gate_q |=> !pixel_clock_pin_o)
		else $error("pixel clock passed while gated");
	a_read_enables: assert property ((rd_en && addr == ENABLES_OFS) |=> rd_data == {2'h0, $past(st_reg.enables)})
		else $error("enable register read back wrong");

endmodule

/* File: rtl/dos_pkg.sv */
// constants and register map of the display output stage
package dos_pkg;
	// register byte offsets
	localparam logic [15:0] GAMMA_CTRL_OFS     = 16'h1300;
	localparam logic [15:0] LEVELS_OFS         = 16'h1380;
	localparam logic [15:0] LEVELS_LAST_OFS    = 16'h13b4;
	localparam logic [15:0] BIAS_OFS           = 16'h1400;
	localparam logic [15:0] COEF_G_OFS         = 16'h1408;
	localparam logic [15:0] COEF_R_OFS         = 16'h140c;
	localparam logic [15:0] COEF_B_OFS         = 16'h1410;
	localparam logic [15:0] GAMMA_TAB_OFS      = 16'h2800;
	localparam logic [15:0] GAMMA_TAB_LAST_OFS = 16'h2bfc;
	localparam logic [15:0] CTRL_OFS           = 16'h3000;
	localparam logic [15:0] FORMAT_OFS         = 16'h3004;
	localparam logic [15:0] STATUS_OFS         = 16'h3008;
	localparam logic [15:0] ACLAMP_OFS         = 16'h3258;
	localparam logic [15:0] DCLAMP_OFS         = 16'h325c;
	localparam logic [15:0] ENABLES_OFS        = 16'h3260;
	// field positions
	localparam int ENA_HSYNC_BIT   = 24;
	localparam int ENA_VSYNC_BIT   = 25;
	localparam int ENA_VREF_BIT    = 26;
	localparam int ENA_CKEY_BIT    = 27;
	localparam int ENA_DAC_BIT     = 28;
	localparam int ENA_REF_BIT     = 29;
	localparam int FMT_PHYS_LSB    = 0;
	localparam int FMT_STREAM_LSB  = 8;
	localparam int FMT_SCAN_LSB    = 16;
	localparam int FMT_TWIN_BIT    = 18;
	localparam int GAMMA_EN_BIT    = 7;
	localparam int CTRL_EXT_SYNC   = 0;
	localparam int CTRL_CHROMA_INT = 1;
	localparam int CTRL_MATRIX_EN  = 2;
	localparam int CTRL_INTER_LSB  = 4;
	// table sizes
	localparam int LEVELS_N = 14;
	localparam int GAMMA_N  = 256;
	// physical colour space codes
	localparam logic [3:0] PHYS_1BPP   = 4'h0;
	localparam logic [3:0] PHYS_RGB111 = 4'h1;
	localparam logic [3:0] PHYS_4BPP   = 4'h2;
	localparam logic [3:0] PHYS_RGB333 = 4'h3;
	localparam logic [3:0] PHYS_RGB444 = 4'h4;
	localparam logic [3:0] PHYS_RGB666 = 4'h5;
	localparam logic [3:0] PHYS_RGB888 = 4'h6;
	// intermediate colour space codes
	localparam logic [3:0] INTER_4BPP   = 4'h2;
	localparam logic [3:0] INTER_RGB222 = 4'h7;
	// bit stream format codes
	localparam logic [3:0] STREAM_S9            = 4'h5;
	localparam logic [3:0] STREAM_S24           = 4'h8;
	localparam logic [3:0] analog_stream_format = 4'h9;
	// scan modes
	localparam logic [1:0] single_scan_mode   = 2'h0;
	localparam logic [1:0] two_half_scan_mode = 2'h1;
	localparam logic [1:0] zigzag_scan_mode   = 2'h2;
	// values after reset
	localparam logic [23:0] BIAS_RST   = 24'h00_0000;
	localparam logic [23:0] COEF_G_RST = 24'h80_0000;
	localparam logic [15:0] COEF_R_RST = 16'h8000;
	localparam logic [15:0] COEF_B_RST = 16'h8000;
endpackage
